// *** rtl/fxc_abcd_conv.sv ***
// Purpose: abcd signaling conversion between ansi and ccitt
// Assumes: combinational, registered by the caller
// Notes: mapping a->a, b->b; tx c/d forced to 0/1, rx c/d copy a/b
`timescale 1ns/100ps
`default_nettype none
module fxc_abcd_conv (
    input wire logic enable,
    input wire logic [3:0] tx_in,
    input wire logic [3:0] rx_in,
    output logic [3:0] tx_out,
    output logic [3:0] rx_out
);
    always_comb begin
        tx_out = tx_in;
        rx_out = rx_in;
        if (enable) begin
            tx_out = {tx_in[3:2], 2'h1};
            rx_out = {rx_in[3:2], rx_in[3:2]};
        end
    end
endmodule : fxc_abcd_conv
`default_nettype wire

// *** rtl/fxc_pkg.sv ***
// Purpose: shared constants and types for the port channel control
// Assumes: 100 MHz clk, synchronous active-low reset
// Notes: Operation list below
// Operation
// - per-port mu-law, A-law or inverted A-law
// - inverted A-law inverts A-law code bits
// - alarm enters idle or busy conditioning
// - active call held two seconds, then busy
// - alarm clear returns port to idle
// - loopback none, digital or analog
// - milliwatt tone only on selected port
// - hybrid balance held as three bytes
// - wink delay 0-99 in 100 ms steps
// - wink duration 1-99 in 100 ms steps
// - wink timing only in dn or dpt
// - conversion maps tx ansi-ccitt, rx ccitt-ansi
// - conversion independent of aggregate type
// - 64k rate uses no adpcm resources
// - suffix 1 odd half, 2 even half
// - card select n/a at 64k, else slot
// - no server card locks the rate
// - edits pending until save; undo restores
package fxc_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned TICK_MS = 100;
    localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned HOLD_MS = 2000;
    localparam logic [7:0] HOLD_TICKS = 8'(HOLD_MS / TICK_MS);
    localparam logic [6:0] WINK_MAX = 7'h63;
    localparam logic [7:0] ALAW_XOR = 8'h55;
    localparam logic [7:0] MILLIWATT_LEN = 8'h08;
    localparam logic [23:0] HYBRID_SET1 = 24'h000001;

    typedef enum logic [1:0] {
        FXC_MULAW = 2'h0, FXC_ALAW = 2'h1, FXC_AINV = 2'h2, FXC_LAW_RSV = 2'h3
    } fxc_law_e;
    typedef enum logic [1:0] {
        FXC_LB_OFF = 2'h0, FXC_LB_DGTL = 2'h1, FXC_LB_ANLG = 2'h2,
        FXC_LB_RSV = 2'h3
    } fxc_lb_e;
    typedef enum logic [1:0] {
        FXC_PAT_NONE = 2'h0, FXC_PAT_MW = 2'h1, FXC_PAT_QUIET = 2'h2,
        FXC_PAT_RSV = 2'h3
    } fxc_pat_e;
    typedef enum logic [1:0] {
        FXC_MODE_FXO = 2'h0, FXC_MODE_FXODN = 2'h1, FXC_MODE_DPT = 2'h2,
        FXC_MODE_MRD = 2'h3
    } fxc_mode_e;
    typedef enum logic [1:0] {
        FXC_SIG_DPT = 2'h0, FXC_SIG_R2 = 2'h1, FXC_SIG_IR2 = 2'h2,
        FXC_SIG_OTHER = 2'h3
    } fxc_sig_e;
    // rate code: 0=64k, 1..3 = 24/32/40k suffix 1, 4..6 = suffix 2
    typedef enum logic [2:0] {
        FXC_R64 = 3'h0, FXC_R24_1 = 3'h1, FXC_R32_1 = 3'h2, FXC_R40_1 = 3'h3,
        FXC_R24_2 = 3'h4, FXC_R32_2 = 3'h5, FXC_R40_2 = 3'h6,
        FXC_RRSV = 3'h7
    } fxc_rate_e;
    // adpcm card: 0 = n/a
    typedef enum logic [1:0] {
        FXC_CARD_NA = 2'h0, FXC_CARD_SLOT1 = 2'h1, FXC_CARD_SLOT2 = 2'h2,
        FXC_CARD_SLOT3 = 2'h3
    } fxc_card_e;
    typedef enum logic [1:0] {
        FXC_T_IDLE = 2'h0, FXC_T_HOLD = 2'h1, FXC_T_BUSY = 2'h2,
        FXC_T_IDLECOND = 2'h3
    } fxc_trunk_e;
    typedef enum logic [1:0] {
        FXC_W_IDLE = 2'h0, FXC_W_DELAY = 2'h1, FXC_W_WINK = 2'h2,
        FXC_W_DONE = 2'h3
    } fxc_wink_e;

    typedef struct packed {
        fxc_law_e law;
        logic cond_busy;
        fxc_lb_e loopback;
        fxc_pat_e pattern;
        logic [23:0] hybrid;
        logic [6:0] wink_delay;
        logic [6:0] wink_len;
        logic signaling_bit_conversion;
        fxc_rate_e rate;
        fxc_card_e card;
    } fxc_cfg_s;

    localparam fxc_cfg_s CFG_RESET = '{
        law: FXC_MULAW, cond_busy: 1'b0, loopback: FXC_LB_OFF,
        pattern: FXC_PAT_NONE, hybrid: HYBRID_SET1, wink_delay: 7'h00,
        wink_len: 7'h00, signaling_bit_conversion: 1'b0, rate: FXC_R64, card: FXC_CARD_NA
    };
endpackage : fxc_pkg

// *** rtl/fxc_port_ctrl.sv ***
// Purpose: per-port channel control of an office-side voice port
// Assumes: one clock, synchronous active-low reset, pins synchronised
// Notes: settings staged, committed by save, restored by undo
`timescale 1ns/100ps
`default_nettype none
module fxc_port_ctrl (
    input wire logic clk,
    input wire logic rst_n,
    input wire fxc_pkg::fxc_cfg_s edit_cfg,
    input wire logic edit_we,
    input wire logic save,
    input wire logic undo,
    input wire logic server_present,
    input wire fxc_pkg::fxc_mode_e mode,
    input wire fxc_pkg::fxc_sig_e sig_type,
    input wire logic port_selected,
    input wire logic alarm_pin,
    input wire logic call_active,
    input wire logic seize,
    input wire logic [7:0] tx_pcm,
    input wire logic [7:0] rx_pcm,
    input wire logic [3:0] tx_abcd,
    input wire logic [3:0] rx_abcd,
    output fxc_pkg::fxc_cfg_s pending_cfg,
    output fxc_pkg::fxc_cfg_s active_cfg,
    output logic [7:0] line_tx,
    output logic [7:0] line_rx,
    output logic [3:0] line_tx_abcd,
    output logic [3:0] line_rx_abcd,
    output logic digital_lb,
    output logic analog_lb,
    output logic quiet_term,
    output logic busy_out,
    output logic call_release,
    output logic wink,
    output logic adpcm_used,
    output logic adpcm_even,
    output logic [1:0] adpcm_rate
);
    ////////////////////////////////////////////////////////////////////
    // pins and tick
    logic alarm_s1;
    logic alarm;
    logic tick;
    fxc_tick u_tick (
        .clk(clk),
        .rst_n(rst_n),
        .tick(tick)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            alarm_s1 <= 1'b0;
            alarm <= 1'b0;
        end else begin
            alarm_s1 <= alarm_pin;
            alarm <= alarm_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // configuration staging
    fxc_pkg::fxc_cfg_s next_pending;
    fxc_pkg::fxc_cfg_s next_active;

    always_comb begin
        next_pending = pending_cfg;
        next_active = active_cfg;
        if (edit_we) begin
            next_pending = edit_cfg;
            if (!server_present) begin
                next_pending.rate = pending_cfg.rate;
            end
            if (edit_cfg.law == fxc_pkg::FXC_LAW_RSV) begin
                next_pending.law = pending_cfg.law;
            end
            if (edit_cfg.hybrid != fxc_pkg::HYBRID_SET1) begin
                next_pending.hybrid = fxc_pkg::HYBRID_SET1;
            end
            if (edit_cfg.wink_delay > fxc_pkg::WINK_MAX) begin
                next_pending.wink_delay = pending_cfg.wink_delay;
            end
            if (edit_cfg.wink_len > fxc_pkg::WINK_MAX) begin
                next_pending.wink_len = pending_cfg.wink_len;
            end
            if (next_pending.rate == fxc_pkg::FXC_R64) begin
                next_pending.card = fxc_pkg::FXC_CARD_NA;
            end else if (edit_cfg.card == fxc_pkg::FXC_CARD_NA) begin
                next_pending.card = fxc_pkg::FXC_CARD_SLOT1;
            end
        end
        if (save) begin
            next_active = pending_cfg;
        end else if (undo) begin
            next_pending = active_cfg;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pending_cfg <= fxc_pkg::CFG_RESET;
            active_cfg <= fxc_pkg::CFG_RESET;
        end else begin
            pending_cfg <= next_pending;
            active_cfg <= next_active;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // trunk conditioning on carrier group alarm
    fxc_pkg::fxc_trunk_e trunk;
    fxc_pkg::fxc_trunk_e next_trunk;
    logic [7:0] hold_cnt;
    logic [7:0] next_hold_cnt;
    logic next_busy_out;
    logic next_call_release;

    always_comb begin
        next_trunk = trunk;
        next_hold_cnt = hold_cnt;
        next_call_release = 1'b0;
        unique case (trunk)
            fxc_pkg::FXC_T_IDLE: begin
                if (alarm) begin
                    if (call_active) begin
                        next_trunk = fxc_pkg::FXC_T_HOLD;
                        next_hold_cnt = fxc_pkg::HOLD_TICKS;
                    end else if (active_cfg.cond_busy) begin
                        next_trunk = fxc_pkg::FXC_T_BUSY;
                    end else begin
                        next_trunk = fxc_pkg::FXC_T_IDLECOND;
                    end
                end
            end
            fxc_pkg::FXC_T_HOLD: begin
                if (!alarm) begin
                    next_trunk = fxc_pkg::FXC_T_IDLE;
                end else if (tick) begin
                    next_hold_cnt = hold_cnt - 8'h01;
                    if (hold_cnt == 8'h01) begin
                        next_trunk = fxc_pkg::FXC_T_BUSY;
                        next_call_release = 1'b1;
                    end
                end
            end
            fxc_pkg::FXC_T_BUSY, fxc_pkg::FXC_T_IDLECOND: begin
                if (!alarm) begin
                    next_trunk = fxc_pkg::FXC_T_IDLE;
                end
            end
        endcase
        next_busy_out = (next_trunk == fxc_pkg::FXC_T_BUSY);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            trunk <= fxc_pkg::FXC_T_IDLE;
            hold_cnt <= 8'h00;
            busy_out <= 1'b0;
            call_release <= 1'b0;
        end else begin
            trunk <= next_trunk;
            hold_cnt <= next_hold_cnt;
            busy_out <= next_busy_out;
            call_release <= next_call_release;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // wink delay and duration
    fxc_pkg::fxc_wink_e wst;
    fxc_pkg::fxc_wink_e next_wst;
    logic [6:0] wcnt;
    logic [6:0] next_wcnt;
    logic wink_on;
    logic next_wink;

    always_comb begin
        wink_on = (mode == fxc_pkg::FXC_MODE_FXODN) ||
            (mode == fxc_pkg::FXC_MODE_DPT &&
            (sig_type == fxc_pkg::FXC_SIG_R2 ||
            sig_type == fxc_pkg::FXC_SIG_IR2));
        next_wst = wst;
        next_wcnt = wcnt;
        unique case (wst)
            fxc_pkg::FXC_W_IDLE: begin
                if (seize && wink_on && active_cfg.wink_len != 7'h00) begin
                    next_wst = fxc_pkg::FXC_W_DELAY;
                    next_wcnt = active_cfg.wink_delay;
                end
            end
            fxc_pkg::FXC_W_DELAY: begin
                if (wcnt == 7'h00) begin
                    next_wst = fxc_pkg::FXC_W_WINK;
                    next_wcnt = active_cfg.wink_len;
                end else if (tick) begin
                    next_wcnt = wcnt - 7'h01;
                end
            end
            fxc_pkg::FXC_W_WINK: begin
                if (wcnt == 7'h00) begin
                    next_wst = fxc_pkg::FXC_W_DONE;
                end else if (tick) begin
                    next_wcnt = wcnt - 7'h01;
                end
            end
            fxc_pkg::FXC_W_DONE: begin
                if (!seize) begin
                    next_wst = fxc_pkg::FXC_W_IDLE;
                end
            end
        endcase
        if (!wink_on) begin
            next_wst = fxc_pkg::FXC_W_IDLE;
        end
        next_wink = (next_wst == fxc_pkg::FXC_W_WINK);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wst <= fxc_pkg::FXC_W_IDLE;
            wcnt <= 7'h00;
            wink <= 1'b0;
        end else begin
            wst <= next_wst;
            wcnt <= next_wcnt;
            wink <= next_wink;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // voice path: coding, loopback, test pattern, signaling, adpcm
    logic [63:0] mw_code;
    logic [2:0] mw_idx;
    logic [2:0] next_mw_idx;
    logic [7:0] enc_tx;
    logic [7:0] next_line_tx;
    logic [7:0] next_line_rx;
    logic [3:0] conv_tx;
    logic [3:0] conv_rx;
    logic mw_on;

    // milliwatt sequence, mu-law codes, 8 samples per 1 kHz cycle
    assign mw_code = 64'h1E0B0B1E9E8B8B9E;

    fxc_abcd_conv u_conv (
        .enable(active_cfg.signaling_bit_conversion),
        .tx_in(tx_abcd),
        .rx_in(rx_abcd),
        .tx_out(conv_tx),
        .rx_out(conv_rx)
    );

    always_comb begin
        mw_on = port_selected &&
            active_cfg.pattern == fxc_pkg::FXC_PAT_MW;
        next_mw_idx = mw_on ? mw_idx + 3'h1 : 3'h0;
        enc_tx = mw_on ? mw_code[{~mw_idx, 3'h0} +: 8] : tx_pcm;
        if (port_selected &&
            active_cfg.pattern == fxc_pkg::FXC_PAT_QUIET) begin
            enc_tx = 8'hFF;
        end
        if (active_cfg.loopback == fxc_pkg::FXC_LB_DGTL) begin
            enc_tx = rx_pcm;
        end
        unique case (active_cfg.law)
            fxc_pkg::FXC_AINV: next_line_tx = ~(enc_tx ^ fxc_pkg::ALAW_XOR);
            fxc_pkg::FXC_ALAW: next_line_tx = enc_tx ^ fxc_pkg::ALAW_XOR;
            default: next_line_tx = enc_tx;
        endcase
        unique case (active_cfg.law)
            fxc_pkg::FXC_AINV: next_line_rx = ~(rx_pcm ^ fxc_pkg::ALAW_XOR);
            fxc_pkg::FXC_ALAW: next_line_rx = rx_pcm ^ fxc_pkg::ALAW_XOR;
            default: next_line_rx = rx_pcm;
        endcase
        if (active_cfg.loopback == fxc_pkg::FXC_LB_ANLG) begin
            next_line_rx = next_line_tx;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mw_idx <= 3'h0;
            line_tx <= 8'h00;
            line_rx <= 8'h00;
            line_tx_abcd <= 4'h0;
            line_rx_abcd <= 4'h0;
            digital_lb <= 1'b0;
            analog_lb <= 1'b0;
            quiet_term <= 1'b0;
            adpcm_used <= 1'b0;
            adpcm_even <= 1'b0;
            adpcm_rate <= 2'h0;
        end else begin
            mw_idx <= next_mw_idx;
            line_tx <= next_line_tx;
            line_rx <= next_line_rx;
            line_tx_abcd <= conv_tx;
            line_rx_abcd <= conv_rx;
            digital_lb <= active_cfg.loopback == fxc_pkg::FXC_LB_DGTL;
            analog_lb <= active_cfg.loopback == fxc_pkg::FXC_LB_ANLG;
            quiet_term <= port_selected &&
                active_cfg.pattern == fxc_pkg::FXC_PAT_QUIET;
            adpcm_used <= active_cfg.rate != fxc_pkg::FXC_R64;
            adpcm_even <= active_cfg.rate >= fxc_pkg::FXC_R24_2;
            adpcm_rate <= (active_cfg.rate >= fxc_pkg::FXC_R24_2) ?
                2'(active_cfg.rate - fxc_pkg::FXC_R40_1) :
                active_cfg.rate[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    property p_hold;
        @(posedge clk) disable iff (!rst_n)
        (trunk == fxc_pkg::FXC_T_IDLE && alarm && call_active) |=>
        (trunk == fxc_pkg::FXC_T_HOLD && hold_cnt == 8'h14);
    endproperty
    a_hold: assert property (p_hold) else $error("hold not started");
    property p_release;
        @(posedge clk) disable iff (!rst_n)
        call_release |-> busy_out;
    endproperty
    a_release: assert property (p_release) else $error("bad release");
    property p_cond;
        @(posedge clk) disable iff (!rst_n)
        (trunk == fxc_pkg::FXC_T_IDLE && alarm && !call_active) |=>
        busy_out == $past(active_cfg.cond_busy);
    endproperty
    a_cond: assert property (p_cond) else $error("bad conditioning");
    property p_clear;
        @(posedge clk) disable iff (!rst_n)
        (!alarm && trunk != fxc_pkg::FXC_T_IDLE) |=> !busy_out;
    endproperty
    a_clear: assert property (p_clear) else $error("no idle on clear");
    property p_save;
        @(posedge clk) disable iff (!rst_n)
        save |=> active_cfg == $past(pending_cfg);
    endproperty
    a_save: assert property (p_save) else $error("save lost");
    property p_undo;
        @(posedge clk) disable iff (!rst_n)
        (undo && !save) |=> pending_cfg == $past(active_cfg);
    endproperty
    a_undo: assert property (p_undo) else $error("undo lost");
    property p_lock;
        @(posedge clk) disable iff (!rst_n)
        (!server_present && !undo) |=>
        pending_cfg.rate == $past(pending_cfg.rate);
    endproperty
    a_lock: assert property (p_lock) else $error("rate changed");
    property p_card;
        @(posedge clk) disable iff (!rst_n)
        pending_cfg.rate == fxc_pkg::FXC_R64 && !undo |->
        ##1 (pending_cfg.rate != fxc_pkg::FXC_R64 ||
        pending_cfg.card == fxc_pkg::FXC_CARD_NA);
    endproperty
    a_card: assert property (p_card) else $error("card not n/a");
    property p_wink_mode;
        @(posedge clk) disable iff (!rst_n)
        !wink_on |=> !wink;
    endproperty
    a_wink_mode: assert property (p_wink_mode) else $error("bad wink");
    property p_adpcm;
        @(posedge clk) disable iff (!rst_n)
        active_cfg.rate == fxc_pkg::FXC_R64 ##1
        active_cfg.rate == fxc_pkg::FXC_R64 |-> !adpcm_used;
    endproperty
    a_adpcm: assert property (p_adpcm) else $error("64k uses adpcm");
endmodule : fxc_port_ctrl
`default_nettype wire

// *** rtl/fxc_tick.sv ***
// Purpose: 100 ms tick from the system clock
// Assumes: clk at fxc_pkg::CLK_HZ
// Notes: one-cycle pulse per period
`timescale 1ns/100ps
`default_nettype none
module fxc_tick (
    input wire logic clk,
    input wire logic rst_n,
    output logic tick
);
    logic [23:0] cnt;
    logic [23:0] next_cnt;
    logic next_tick;

    always_comb begin
        next_tick = 1'b0;
        next_cnt = cnt + 24'h000001;
        if (cnt == 24'(fxc_pkg::TICK_CYC - 1)) begin
            next_cnt = 24'h000000;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt <= 24'h000000;
            tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule : fxc_tick
`default_nettype wire

// *** tb/fxc_port_ctrl_tb.sv ***
// Purpose: self-checking bench of the port channel control
// Assumes: tick too long to reach, timers left to assertions
// Notes: random samples from seed 52
`timescale 1ns/100ps
`default_nettype none
module fxc_port_ctrl_tb;
    logic clk, rst_n, edit_we, save, undo, port_selected, seize;
    logic call_active, alarm_cmd, server_cmd, alarm_pin, server_present;
    logic digital_lb, analog_lb, quiet_term, busy_out, call_release, wink;
    logic adpcm_used, adpcm_even;
    logic [1:0] adpcm_rate, peer_rate;
    logic [7:0] tx_pcm, rx_pcm, line_tx, line_rx, q;
    logic [3:0] tx_abcd, rx_abcd, line_tx_abcd, line_rx_abcd, r;
    fxc_pkg::fxc_cfg_s edit_cfg, pending_cfg, active_cfg, c, d;
    fxc_pkg::fxc_mode_e mode;
    fxc_pkg::fxc_sig_e sig_type;
    int errors, compares, seed, i, n;
    localparam logic [63:0] MW_REF = 64'h1E0B0B1E9E8B8B9E;

    fxc_port_ctrl dut (.clk, .rst_n, .edit_cfg, .edit_we, .save, .undo,
        .server_present, .mode, .sig_type, .port_selected, .alarm_pin,
        .call_active, .seize, .tx_pcm, .rx_pcm, .tx_abcd, .rx_abcd,
        .pending_cfg, .active_cfg, .line_tx, .line_rx, .line_tx_abcd,
        .line_rx_abcd, .digital_lb, .analog_lb, .quiet_term, .busy_out,
        .call_release, .wink, .adpcm_used, .adpcm_even, .adpcm_rate);
    fxc_wan_model u_wan (.clk, .alarm_cmd, .server_cmd,
        .port_rate(adpcm_rate), .alarm_pin, .server_present, .rx_pcm,
        .rx_abcd, .peer_rate);

    initial clk = 1'b0;
    always #5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk8(input string w, input logic [7:0] e, g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", w, e, g);
        end
    endtask : chk8
    task automatic chkc(input string w, input fxc_pkg::fxc_cfg_s e, g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", w, e, g);
        end
    endtask : chkc
    task automatic wr(input fxc_pkg::fxc_cfg_s v);
        @(posedge clk);
        edit_cfg <= v;
        edit_we <= 1'b1;
        @(posedge clk);
        edit_we <= 1'b0;
        #1;
    endtask : wr
    task automatic act(input logic s, input logic u);
        @(posedge clk);
        save <= s;
        undo <= u;
        @(posedge clk);
        save <= 1'b0;
        undo <= 1'b0;
        #1;
    endtask : act
    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wait_busy(input logic v);
        for (n = 0; n < 8 && busy_out !== v; n++) cyc(1);
        chk8("busy_out", 8'(v), 8'(busy_out));
        if (busy_out !== v) end_sim();
    endtask : wait_busy
    function automatic logic [7:0] enc(input fxc_pkg::fxc_law_e l,
                                       input logic [7:0] s);
        case (l)
            fxc_pkg::FXC_ALAW: enc = s ^ fxc_pkg::ALAW_XOR;
            fxc_pkg::FXC_AINV: enc = ~(s ^ fxc_pkg::ALAW_XOR);
            default: enc = s;
        endcase
    endfunction : enc

    ////////////////////////////////////////////////////////////////////
    initial begin
        seed = 52;
        errors = 0;
        compares = 0;
        rst_n = 1'b0;
        edit_cfg = fxc_pkg::CFG_RESET;
        {edit_we, save, undo, port_selected, seize, call_active} = '0;
        alarm_cmd = 1'b0;
        server_cmd = 1'b1;
        mode = fxc_pkg::FXC_MODE_FXO;
        sig_type = fxc_pkg::FXC_SIG_DPT;
        tx_pcm = 8'h00;
        tx_abcd = 4'h0;
        cyc(12);
        chkc("reset", fxc_pkg::CFG_RESET, active_cfg);
        chk8("reset out", 8'h00, 8'({busy_out, adpcm_used, wink}));
        rst_n <= 1'b1;
        c = fxc_pkg::CFG_RESET;
        c.law = fxc_pkg::FXC_ALAW;
        c.cond_busy = 1'b1;
        c.wink_delay = 7'h63;
        c.wink_len = 7'h01;
        c.signaling_bit_conversion = 1'b1;
        wr(c);
        chkc("pending", c, pending_cfg);
        chkc("active", fxc_pkg::CFG_RESET, active_cfg);
        act(1'b0, 1'b1);
        chkc("undo", fxc_pkg::CFG_RESET, pending_cfg);
        wr(c);
        act(1'b1, 1'b0);
        chkc("save", c, active_cfg);
        d = c;
        d.wink_delay = 7'h64;
        d.wink_len = 7'h7F;
        d.law = fxc_pkg::FXC_LAW_RSV;
        d.hybrid = 24'hABCDEF;
        wr(d);
        chkc("refuse", c, pending_cfg);
        for (i = 0; i < 12; i++) begin
            if (i % 4 == 0) begin
                c.law = fxc_pkg::fxc_law_e'(i / 4);
                wr(c);
                act(1'b1, 1'b0);
            end
            @(posedge clk);
            tx_pcm <= (i == 3) ? 8'hFF : 8'($random(seed));
            #1;
            q = rx_pcm;
            cyc(1);
            chk8("line_tx", enc(c.law, tx_pcm), line_tx);
            chk8("line_rx", enc(c.law, q), line_rx);
        end
        for (i = 0; i < 16; i++) begin
            if (i == 8) begin
                c.signaling_bit_conversion = 1'b0;
                wr(c);
                act(1'b1, 1'b0);
            end
            @(posedge clk);
            tx_abcd <= 4'($random(seed));
            #1;
            r = rx_abcd;
            cyc(1);
            if (i < 8) begin
                chk8("tx cv", {tx_abcd[3:2], 2'h1}, line_tx_abcd);
                chk8("rx abcd", {r[3:2], r[3:2]}, line_rx_abcd);
            end else begin
                chk8("tx plain", 8'(tx_abcd), 8'(line_tx_abcd));
                chk8("rx plain", 8'(r), 8'(line_rx_abcd));
            end
        end
        for (i = 0; i < 3; i++) begin
            c.loopback = fxc_pkg::fxc_lb_e'(i);
            wr(c);
            act(1'b1, 1'b0);
            q = rx_pcm;
            cyc(1);
            chk8("loops", 8'(i), 8'({analog_lb, digital_lb}));
            if (i == 1) begin
                chk8("dgtl", enc(c.law, q), line_tx);
            end else if (i == 2) begin
                chk8("anlg", enc(c.law, tx_pcm), line_rx);
            end
        end
        c.loopback = fxc_pkg::FXC_LB_OFF;
        c.pattern = fxc_pkg::FXC_PAT_QUIET;
        wr(c);
        act(1'b1, 1'b0);
        cyc(1);
        chk8("quiet off", 8'h00, 8'(quiet_term));
        port_selected <= 1'b1;
        cyc(2);
        chk8("quiet on", 8'h01, 8'(quiet_term));
        chk8("quiet tx", enc(c.law, 8'hFF), line_tx);
        port_selected <= 1'b0;
        c.pattern = fxc_pkg::FXC_PAT_MW;
        wr(c);
        act(1'b1, 1'b0);
        tx_pcm <= 8'h3C;
        cyc(2);
        chk8("mw unsel", enc(c.law, 8'h3C), line_tx);
        port_selected <= 1'b1;
        for (i = 0; i < 8; i++) begin
            cyc(1);
            chk8("mw", enc(c.law, MW_REF[56 - 8 * i +: 8]), line_tx);
        end
        port_selected <= 1'b0;
        for (i = 0; i < 7; i++) begin
            c.rate = fxc_pkg::fxc_rate_e'(i);
            c.card = (i == 6) ? fxc_pkg::FXC_CARD_SLOT3 : fxc_pkg::FXC_CARD_NA;
            wr(c);
            act(1'b1, 1'b0);
            cyc(1);
            chk8("card", (i == 0) ? 8'h00 : (i == 6) ? 8'h03 : 8'h01,
                 8'(active_cfg.card));
            chk8("used", 8'(i != 0), 8'(adpcm_used));
            chk8("even", 8'(i > 3), 8'(adpcm_even));
            chk8("rate", (i == 0) ? 8'h00 : 8'((i - 1) % 3 + 1),
                 8'(adpcm_rate));
            chk8("pair", 8'h00, 8'(2'(adpcm_rate + peer_rate)));
        end
        server_cmd <= 1'b0;
        d = c;
        d.rate = fxc_pkg::FXC_R24_1;
        cyc(2);
        wr(d);
        chkc("locked", c, pending_cfg);
        server_cmd <= 1'b1;
        alarm_cmd <= 1'b1;
        wait_busy(1'b1);
        alarm_cmd <= 1'b0;
        wait_busy(1'b0);
        c.cond_busy = 1'b0;
        wr(c);
        act(1'b1, 1'b0);
        alarm_cmd <= 1'b1;
        cyc(8);
        chk8("idle cond", 8'h00, 8'(busy_out));
        alarm_cmd <= 1'b0;
        c.cond_busy = 1'b1;
        wr(c);
        act(1'b1, 1'b0);
        call_active <= 1'b1;
        alarm_cmd <= 1'b1;
        cyc(8);
        chk8("call held", 8'h00, 8'({busy_out, call_release}));
        c.wink_delay = 7'h00;
        wr(c);
        act(1'b1, 1'b0);
        mode <= fxc_pkg::FXC_MODE_DPT;
        sig_type <= fxc_pkg::FXC_SIG_IR2;
        seize <= 1'b1;
        cyc(3);
        chk8("wink on", 8'h01, 8'(wink));
        sig_type <= fxc_pkg::FXC_SIG_DPT;
        cyc(2);
        chk8("wink off", 8'h00, 8'(wink));
        end_sim();
    end
endmodule : fxc_port_ctrl_tb
`default_nettype wire

// *** tb/fxc_wan_model.sv ***
// Purpose: link multiplexer and compression server stand-in
// Assumes: commands from the bench at clock edges
// Notes: receive samples change every cycle, never stale
`timescale 1ns/100ps
`default_nettype none
module fxc_wan_model (
    input wire logic clk,
    input wire logic alarm_cmd,
    input wire logic server_cmd,
    input wire logic [1:0] port_rate,
    output logic alarm_pin,
    output logic server_present,
    output logic [7:0] rx_pcm,
    output logic [3:0] rx_abcd,
    output logic [1:0] peer_rate
);
    initial begin
        alarm_pin = 1'b0;
        server_present = 1'b0;
        rx_pcm = 8'h00;
        rx_abcd = 4'h0;
    end
    always @(posedge clk) begin
        alarm_pin <= alarm_cmd;
        server_present <= server_cmd;
        rx_pcm <= rx_pcm + 8'h25;
        rx_abcd <= rx_abcd + 4'h7;
    end
    // peer half takes the complementary rate
    assign peer_rate = 2'h0 - port_rate;
endmodule : fxc_wan_model
`default_nettype wire
